// File: cxc_bus_node.sv
// Model of the CAN bus and of the receive pin readback.
// Assumes the bench sets the fault knobs at clock edges.
`timescale 1ns/1ps
`default_nettype none
module cxc_bus_node (
    input wire logic bus_tx_dominant,
    input wire logic can_rx_output,
    input wire logic other_dom,
    input wire logic bus_open,
    input wire logic rx_stuck,
    output logic bus_rx_level,
    output logic can_rx_sense
);
    // driver cut off
    // Wired bus: any driving node makes it dominant; our own driver counts only while not cut off.
    assign bus_rx_level = !((bus_tx_dominant && !bus_open) || other_dom);
    // pin clamp
    // A clamped receive pin reads back recessive.
    assign can_rx_sense = rx_stuck | can_rx_output;
endmodule
`default_nettype wire

// File: cxc_chk.sv
// Concurrent checks on the CAN control block pins.
// Assumes it is bound into cxc_top and shares its aclk and aresetn.
`timescale 1ns/1ps
`default_nettype none
`include "cxc_map.svh"
module cxc_chk #(
    parameter int unsigned TDOM_US = 1000,
    parameter int unsigned RST_US = 2000
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic can_tx_input,
    input wire logic bus_rx_level,
    input wire logic can_rx_output,
    input wire logic bus_tx_dominant,
    input wire logic term_en,
    input wire logic split_en,
    input wire logic bus_lines_gnd,
    input wire logic reset_output_low_out,
    input wire logic reset_output_low_oe,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    localparam int TN = TDOM_US * `CXC_CLK_MHZ;
    localparam int RN = RST_US * `CXC_CLK_MHZ;
    logic [19:0] tcnt_ff, nxt_tcnt, rcnt_ff, nxt_rcnt;
    // Count dominant transmit cycles and cycles with the reset pin pulled low.
    always_comb begin
        nxt_tcnt = can_tx_input ? 20'h0 : tcnt_ff + {19'h0, ~&tcnt_ff};
        nxt_rcnt = reset_output_low_oe ? rcnt_ff + {19'h0, ~&rcnt_ff} : 20'h0;
    end
    // Register the counters, cleared in reset.
    always_ff @(posedge aclk) begin
        tcnt_ff <= aresetn ? nxt_tcnt : 20'h0;
        rcnt_ff <= aresetn ? nxt_rcnt : 20'h0;
    end
    a_tdom_cut: assert property (tcnt_ff > TN + 2 |-> !bus_tx_dominant)
        else $error("transmitter on after dominant timeout");
    a_rst_len: assert property ($fell(reset_output_low_oe)
        |-> rcnt_ff inside {[RN:RN+1]})
        else $error("reset pulse length wrong");
    a_tx_cause: assert property (bus_tx_dominant |-> !$past(can_tx_input))
        else $error("bus driven without dominant input");
    a_rx_cause: assert property (!can_rx_output
        |-> !$past(bus_rx_level) || !$past(can_tx_input))
        else $error("receive output dominant without cause");
    a_gnd_off: assert property (bus_lines_gnd
        |-> !term_en && !split_en && !bus_tx_dominant)
        else $error("grounded bus with termination or driver on");
    a_odrain_low: assert property (reset_output_low_out == 1'b0)
        else $error("reset pin drives high");
    a_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_r_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
endmodule
bind cxc_top cxc_chk #(.TDOM_US(TDOM_US), .RST_US(RST_US)) cxc_chk_i (.*);
`default_nettype wire

// File: cxc_map.svh
// Register offsets, field positions, reset values and timing figures of the CAN control block.
// Assumes a 250 MHz system clock; included by the top module.
`ifndef CXC_MAP_SVH
`define CXC_MAP_SVH

// Bus geometry.
`define CXC_ADDR_W 8
`define CXC_OFS_CTRL 8'h00
`define CXC_OFS_STAT 8'h04
`define CXC_OFS_STATE 8'h08
`define CXC_RESP_OKAY 2'h0
`define CXC_RESP_SLVERR 2'h2

// Control register fields.
`define CXC_CTRL_ACT 0
`define CXC_CTRL_LONLY 1
`define CXC_CTRL_LOOP 2
`define CXC_CTRL_WEN 3
`define CXC_CTRL_PAT 4
`define CXC_CTRL_SBREQ 5
`define CXC_CTRL_SBKIND 6
`define CXC_CTRL_ACT_RST 1'h1

// Status register fields, write one to clear.
`define CXC_ST_TDOM 0
`define CXC_ST_BREC 1
`define CXC_ST_PDOM 2
`define CXC_ST_RXS 3
`define CXC_ST_WAKE 4

// Timing figures.
`define CXC_CLK_MHZ 250
`define CXC_FILT_NS 2000
`define CXC_FILT_CYC ((`CXC_FILT_NS * `CXC_CLK_MHZ) / 1000)
`define CXC_FOLLOW_NS 1000
`define CXC_FOLLOW_CYC ((`CXC_FOLLOW_NS * `CXC_CLK_MHZ) / 1000)
`define CXC_IRQ_NS 4000
`define CXC_IRQ_CYC ((`CXC_IRQ_NS * `CXC_CLK_MHZ) / 1000)
`define CXC_MISS_MAX 3'h4
`define CXC_TMR_W 20

`endif

// File: cxc_pkg.sv
// Types shared by the CAN control block.
// Assumes nothing of its surroundings.
package cxc_pkg;
    typedef enum logic [2:0] {
        ST_ACTIVE = 3'b000,
        ST_SB_IDLE = 3'b001,
        ST_P1 = 3'b010,
        ST_P1_OK = 3'b011,
        ST_GAP = 3'b100,
        ST_GAP_OK = 3'b101,
        ST_P2 = 3'b110
    } cxc_state_t;
endpackage

// File: cxc_timer.sv
// Duration counter used for every timeout and filter of the CAN control block except the follow-check window.
// Assumes run is synchronous to aclk; the count restarts whenever run drops.
`timescale 1ns/1ps
`default_nettype none
module cxc_timer #(
    parameter int W = 20
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic [W-1:0] limit,
    output logic hit
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    // Count while run stays high and hold at the limit.
    always_comb begin
        if (!run) begin
            nxt_cnt = '0;
        end else if (cnt_ff == limit) begin
            nxt_cnt = cnt_ff;
        end else begin
            nxt_cnt = cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // The limit is reached only while run is still high.
    assign hit = run && (cnt_ff == limit);
endmodule
`default_nettype wire

// File: cxc_top.sv
// CAN transceiver control logic with an AXI4-Lite register slave.
// Assumes all pin inputs are synchronous to aclk and bus level 0 means dominant.
// Function
// - Long dominant transmit input disables transmitter, latches flag.
// - Four bus follow failures disable transmitter.
// - Long dominant bus latches flag, transmitter stays.
// - Four receive pin follow failures disable transmitter.
// - Flags readable, clearable; clearing re-enables transmitter.
// - Wake evaluated only in standby with wake enabled.
// - Receive output recessive during standby.
// - Receive output tracks bus right after wake.
// - Pattern wake needs two dominant pulses over 2 us.
// - Recessive gap between pulses exceeds 2 us.
// - Both pulses fall within 1.0 ms window.
// - Standby after permanent dominant wakes on recessive.
// - No pattern: filtered bus transition wakes.
// - Battery standby wake gives reset pulse, else interrupt.
// - Writing active bit zero deactivates until set again.
// - Deactivated: termination off, lines grounded, midpoint off.
// - Listen-only disables transmitter, keeps reception and termination.
// - Loopback routes transmit input to receive output.
// - Supply over or undervoltage never disables transceiver.
// - Reset pulse lasts 2 ms before release.
`timescale 1ns/1ps
`default_nettype none
`include "cxc_map.svh"
module cxc_top
    import cxc_pkg::*;
#(
    parameter int unsigned TDOM_US = 1000,
    parameter int unsigned TPDOM_US = 1000,
    parameter int unsigned WIN_US = 1000,
    parameter int unsigned RST_US = 2000
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`CXC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`CXC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic can_tx_input,
    input wire logic bus_rx_level,
    input wire logic can_rx_sense,
    input wire logic vs_overvoltage,
    input wire logic vs_undervoltage,
    output logic can_rx_output,
    output logic bus_tx_dominant,
    output logic term_en,
    output logic split_en,
    output logic bus_lines_gnd,
    output logic reset_output_low_out,
    output logic reset_output_low_oe,
    output logic lin_rx_output
);
    localparam int unsigned TDOM_CYC = TDOM_US * `CXC_CLK_MHZ;
    localparam int unsigned TPDOM_CYC = TPDOM_US * `CXC_CLK_MHZ;
    localparam int unsigned WIN_CYC = WIN_US * `CXC_CLK_MHZ;
    localparam int unsigned RST_CYC = RST_US * `CXC_CLK_MHZ;

    logic aw_have_ff, w_have_ff, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [`CXC_ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic nxt_aw_have, nxt_w_have, nxt_awready, nxt_wready, nxt_bvalid, nxt_arready;
    logic nxt_rvalid;
    logic [`CXC_ADDR_W-1:0] nxt_awaddr;
    logic [31:0] nxt_wdata, nxt_rdata;
    logic [3:0] nxt_wstrb;
    logic [1:0] nxt_bresp, nxt_rresp;
    logic do_wr, wr_ctrl, wr_stat, wr_hit;

    logic act_ff, lonly_ff, loop_ff, wen_ff, pat_ff, sbreq_ff, sbkind_ff;
    logic nxt_act, nxt_lonly, nxt_loop, nxt_wen, nxt_pat, nxt_sbreq, nxt_sbkind;
    logic f_tdom_ff, f_brec_ff, f_pdom_ff, f_rxs_ff, f_wake_ff;
    logic nxt_f_tdom, nxt_f_brec, nxt_f_pdom, nxt_f_rxs, nxt_f_wake;
    cxc_state_t st_ff, nxt_st;
    logic ref_ff, sg_ff, nxt_ref, nxt_sg, wake;
    logic pulse_on_ff, pkind_ff, nxt_pulse_on, nxt_pkind;
    logic tx_prev_ff, bus_prev_ff;
    logic fol_run_ff, seen_bus_ff, seen_rx_ff, nxt_fol_run, nxt_seen_bus, nxt_seen_rx;
    logic [7:0] fol_cnt_ff, nxt_fol_cnt;
    logic [2:0] miss_bus_ff, miss_rx_ff, nxt_miss_bus, nxt_miss_rx;
    logic set_brec, set_rxs;
    logic rx_ff, txd_ff, term_ff, split_ff, gnd_ff, rst_oe_ff, lin_ff;
    logic in_active, in_pattern, tx_en;
    logic tdom_hit, pdom_hit, flt_hit, win_hit, pulse_hit;
    logic [31:0] rd_mux;

    assign in_active = (st_ff == ST_ACTIVE);
    assign in_pattern = (st_ff != ST_ACTIVE) && (st_ff != ST_SB_IDLE);
    // Supply faults are deliberately not part of this enable.
    assign tx_en = in_active && act_ff && !lonly_ff && !f_tdom_ff && !f_brec_ff && !f_rxs_ff;
    assign do_wr = aw_have_ff && w_have_ff && !bvalid_ff;
    assign wr_ctrl = do_wr && (awaddr_ff == `CXC_OFS_CTRL) && wstrb_ff[0];
    assign wr_stat = do_wr && (awaddr_ff == `CXC_OFS_STAT) && wstrb_ff[0];
    assign wr_hit = (awaddr_ff == `CXC_OFS_CTRL) || (awaddr_ff == `CXC_OFS_STAT);

    cxc_timer #(.W(`CXC_TMR_W)) u_tdom (.aclk(aclk), .aresetn(aresetn),
        .run(in_active && !can_tx_input), .limit(`CXC_TMR_W'(TDOM_CYC)), .hit(tdom_hit));
    cxc_timer #(.W(`CXC_TMR_W)) u_pdom (.aclk(aclk), .aresetn(aresetn),
        .run(in_active && !bus_rx_level), .limit(`CXC_TMR_W'(TPDOM_CYC)), .hit(pdom_hit));
    // Bus level stable for the filter time.
    cxc_timer #(.W(`CXC_TMR_W)) u_flt (.aclk(aclk), .aresetn(aresetn),
        .run(bus_rx_level == bus_prev_ff), .limit(`CXC_TMR_W'(`CXC_FILT_CYC)), .hit(flt_hit));
    cxc_timer #(.W(`CXC_TMR_W)) u_win (.aclk(aclk), .aresetn(aresetn),
        .run(in_pattern), .limit(`CXC_TMR_W'(WIN_CYC)), .hit(win_hit));
    cxc_timer #(.W(`CXC_TMR_W)) u_pulse (.aclk(aclk), .aresetn(aresetn),
        .run(pulse_on_ff), .limit(pkind_ff ? `CXC_TMR_W'(RST_CYC) : `CXC_TMR_W'(`CXC_IRQ_CYC)),
        .hit(pulse_hit));

    // Register read multiplexer.
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr)
            `CXC_OFS_CTRL: rd_mux = {25'h0, sbkind_ff, sbreq_ff, pat_ff, wen_ff, loop_ff,
                lonly_ff, act_ff};
            `CXC_OFS_STAT: rd_mux = {27'h0, f_wake_ff, f_rxs_ff, f_pdom_ff, f_brec_ff,
                f_tdom_ff};
            `CXC_OFS_STATE: rd_mux = {23'h0, pulse_on_ff, vs_undervoltage, vs_overvoltage,
                st_ff, act_ff, !in_active, tx_en};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // AXI4-Lite handshakes: address and data in either order, response one cycle later.
    always_comb begin
        nxt_aw_have = aw_have_ff;
        nxt_awaddr = awaddr_ff;
        nxt_w_have = w_have_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (s_axi_awvalid && awready_ff) begin
            nxt_aw_have = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_ff) begin
            nxt_w_have = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (do_wr) begin
            nxt_aw_have = 1'b0;
            nxt_w_have = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = wr_hit ? `CXC_RESP_OKAY : `CXC_RESP_SLVERR;
        end else if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (s_axi_arvalid && arready_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rdata = rd_mux;
            nxt_rresp = (s_axi_araddr == `CXC_OFS_CTRL || s_axi_araddr == `CXC_OFS_STAT ||
                s_axi_araddr == `CXC_OFS_STATE) ? `CXC_RESP_OKAY : `CXC_RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        nxt_awready = !nxt_aw_have && !nxt_bvalid;
        nxt_wready = !nxt_w_have && !nxt_bvalid;
        nxt_arready = !nxt_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff <= 1'b0;
            awaddr_ff <= '0;
            w_have_ff <= 1'b0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `CXC_RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `CXC_RESP_OKAY;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            arready_ff <= 1'b1;
        end else begin
            aw_have_ff <= nxt_aw_have;
            awaddr_ff <= nxt_awaddr;
            w_have_ff <= nxt_w_have;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            arready_ff <= nxt_arready;
        end
    end

    // Follow checks: after a dominant transmit edge with the transmitter enabled and no check running, watch bus and receive pin.
    always_comb begin
        nxt_fol_run = fol_run_ff;
        nxt_fol_cnt = fol_cnt_ff;
        nxt_seen_bus = seen_bus_ff || !bus_rx_level;
        nxt_seen_rx = seen_rx_ff || !can_rx_sense;
        nxt_miss_bus = miss_bus_ff;
        nxt_miss_rx = miss_rx_ff;
        set_brec = 1'b0;
        set_rxs = 1'b0;
        if (!fol_run_ff) begin
            nxt_seen_bus = 1'b0;
            nxt_seen_rx = 1'b0;
            nxt_fol_cnt = 8'h00;
            nxt_fol_run = tx_en && tx_prev_ff && !can_tx_input;
        end else if (fol_cnt_ff == 8'(`CXC_FOLLOW_CYC - 1)) begin
            nxt_fol_run = 1'b0;
            nxt_miss_bus = nxt_seen_bus ? 3'h0 : miss_bus_ff + 3'h1;
            nxt_miss_rx = nxt_seen_rx ? 3'h0 : miss_rx_ff + 3'h1;
            if (nxt_miss_bus == `CXC_MISS_MAX) begin
                set_brec = 1'b1;
                nxt_miss_bus = 3'h0;
            end
            if (nxt_miss_rx == `CXC_MISS_MAX) begin
                set_rxs = 1'b1;
                nxt_miss_rx = 3'h0;
            end
        end else begin
            nxt_fol_cnt = fol_cnt_ff + 8'h01;
        end
    end

    // Control bits, sticky flags and the standby and wake sequencer.
    always_comb begin
        nxt_act = act_ff;
        nxt_lonly = lonly_ff;
        nxt_loop = loop_ff;
        nxt_wen = wen_ff;
        nxt_pat = pat_ff;
        nxt_sbreq = sbreq_ff;
        nxt_sbkind = sbkind_ff;
        nxt_st = st_ff;
        nxt_ref = ref_ff;
        nxt_sg = sg_ff;
        wake = 1'b0;
        // Software sets or clears the active bit.
        if (wr_ctrl) begin
            nxt_act = wdata_ff[`CXC_CTRL_ACT];
            nxt_lonly = wdata_ff[`CXC_CTRL_LONLY];
            nxt_loop = wdata_ff[`CXC_CTRL_LOOP];
            nxt_wen = wdata_ff[`CXC_CTRL_WEN];
            nxt_pat = wdata_ff[`CXC_CTRL_PAT];
            nxt_sbreq = wdata_ff[`CXC_CTRL_SBREQ];
            nxt_sbkind = wdata_ff[`CXC_CTRL_SBKIND];
        end
        if (st_ff == ST_ACTIVE) begin
            if (sbreq_ff) begin
                nxt_st = ST_SB_IDLE;
                nxt_ref = bus_rx_level;
                nxt_sg = f_pdom_ff;
            end
        end else if (!sbreq_ff) begin
            nxt_st = ST_ACTIVE;
        // Wake only with the wake option enabled.
        end else if (wen_ff) begin
            if (sg_ff) begin
                // Recessive level ends a short to ground.
                wake = bus_rx_level && flt_hit;
            end else if (!pat_ff) begin
                wake = (bus_rx_level != ref_ff) && flt_hit;
            end else if (win_hit) begin
                // Window expired before the second pulse.
                nxt_st = ST_SB_IDLE;
            end else begin
                // Pulse, gap, pulse, each over the filter time.
                case (st_ff)
                    ST_SB_IDLE: if (!bus_rx_level) nxt_st = ST_P1;
                    ST_P1: begin
                        if (bus_rx_level) nxt_st = ST_SB_IDLE;
                        else if (flt_hit) nxt_st = ST_P1_OK;
                    end
                    ST_P1_OK: if (bus_rx_level) nxt_st = ST_GAP;
                    ST_GAP: begin
                        if (!bus_rx_level) nxt_st = ST_P1;
                        else if (flt_hit) nxt_st = ST_GAP_OK;
                    end
                    ST_GAP_OK: if (!bus_rx_level) nxt_st = ST_P2;
                    ST_P2: begin
                        if (bus_rx_level) nxt_st = ST_SB_IDLE;
                        else wake = flt_hit;
                    end
                    default: nxt_st = ST_SB_IDLE;
                endcase
            end
        end
        if (wake) begin
            nxt_st = ST_ACTIVE;
            nxt_sbreq = 1'b0;
        end
        // Set wins over a write-one clear.
        nxt_f_tdom = (f_tdom_ff && !(wr_stat && wdata_ff[`CXC_ST_TDOM])) || tdom_hit;
        nxt_f_brec = (f_brec_ff && !(wr_stat && wdata_ff[`CXC_ST_BREC])) || set_brec;
        nxt_f_pdom = (f_pdom_ff && !(wr_stat && wdata_ff[`CXC_ST_PDOM])) || pdom_hit;
        nxt_f_rxs = (f_rxs_ff && !(wr_stat && wdata_ff[`CXC_ST_RXS])) || set_rxs;
        nxt_f_wake = (f_wake_ff && !(wr_stat && wdata_ff[`CXC_ST_WAKE])) || wake;
        // Pulse kind follows the standby kind left.
        nxt_pulse_on = wake || (pulse_on_ff && !pulse_hit);
        nxt_pkind = wake ? sbkind_ff : pkind_ff;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act_ff <= `CXC_CTRL_ACT_RST;
            lonly_ff <= 1'b0;
            loop_ff <= 1'b0;
            wen_ff <= 1'b0;
            pat_ff <= 1'b0;
            sbreq_ff <= 1'b0;
            sbkind_ff <= 1'b0;
            st_ff <= ST_ACTIVE;
            ref_ff <= 1'b1;
            sg_ff <= 1'b0;
            f_tdom_ff <= 1'b0;
            f_brec_ff <= 1'b0;
            f_pdom_ff <= 1'b0;
            f_rxs_ff <= 1'b0;
            f_wake_ff <= 1'b0;
            pulse_on_ff <= 1'b0;
            pkind_ff <= 1'b0;
            tx_prev_ff <= 1'b1;
            bus_prev_ff <= 1'b1;
            fol_run_ff <= 1'b0;
            fol_cnt_ff <= 8'h00;
            seen_bus_ff <= 1'b0;
            seen_rx_ff <= 1'b0;
            miss_bus_ff <= 3'h0;
            miss_rx_ff <= 3'h0;
        end else begin
            act_ff <= nxt_act;
            lonly_ff <= nxt_lonly;
            loop_ff <= nxt_loop;
            wen_ff <= nxt_wen;
            pat_ff <= nxt_pat;
            sbreq_ff <= nxt_sbreq;
            sbkind_ff <= nxt_sbkind;
            st_ff <= nxt_st;
            ref_ff <= nxt_ref;
            sg_ff <= nxt_sg;
            f_tdom_ff <= nxt_f_tdom;
            f_brec_ff <= nxt_f_brec;
            f_pdom_ff <= nxt_f_pdom;
            f_rxs_ff <= nxt_f_rxs;
            f_wake_ff <= nxt_f_wake;
            pulse_on_ff <= nxt_pulse_on;
            pkind_ff <= nxt_pkind;
            tx_prev_ff <= can_tx_input;
            bus_prev_ff <= bus_rx_level;
            fol_run_ff <= nxt_fol_run;
            fol_cnt_ff <= nxt_fol_cnt;
            seen_bus_ff <= nxt_seen_bus;
            seen_rx_ff <= nxt_seen_rx;
            miss_bus_ff <= nxt_miss_bus;
            miss_rx_ff <= nxt_miss_rx;
        end
    end

    // Registered pin drivers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_ff <= 1'b1;
            txd_ff <= 1'b0;
            term_ff <= 1'b0;
            split_ff <= 1'b0;
            gnd_ff <= 1'b0;
            rst_oe_ff <= 1'b0;
            lin_ff <= 1'b1;
        end else begin
            // Recessive in standby, else loop or bus.
            rx_ff <= (nxt_st != ST_ACTIVE) ? 1'b1 : (loop_ff ? can_tx_input : bus_rx_level);
            txd_ff <= tx_en && nxt_act && !can_tx_input;
            // Termination follows the active bit only.
            term_ff <= nxt_act;
            split_ff <= nxt_act && (nxt_st == ST_ACTIVE);
            gnd_ff <= !nxt_act;
            // Open-drain reset held low for the whole pulse.
            rst_oe_ff <= nxt_pulse_on && nxt_pkind;
            lin_ff <= !(nxt_pulse_on && !nxt_pkind);
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign can_rx_output = rx_ff;
    assign bus_tx_dominant = txd_ff;
    assign term_en = term_ff;
    assign split_en = split_ff;
    assign bus_lines_gnd = gnd_ff;
    // The reset pin only ever pulls low; its enable carries the pulse.
    assign reset_output_low_out = 1'b0;
    assign reset_output_low_oe = rst_oe_ff;
    assign lin_rx_output = lin_ff;
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the CAN control block.
// Assumes cxc_top, the bus model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "cxc_map.svh"
module testbench;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic can_tx_input = 1'b1, vs_overvoltage = 1'b0, vs_undervoltage = 1'b0;
    logic other_dom = 1'b0, bus_open = 1'b0, rx_stuck = 1'b0;
    logic bus_rx_level, can_rx_sense, can_rx_output, bus_tx_dominant, term_en, split_en;
    logic bus_lines_gnd, reset_output_low_out, reset_output_low_oe, lin_rx_output;
    int error_cnt = 0;
    int checked = 0;
    cxc_top #(.TDOM_US(4), .TPDOM_US(8), .WIN_US(8), .RST_US(1)) cxc_top_i (.*);
    cxc_bus_node cxc_bus_node_i (.*);
    // Clock at 250 MHz.
    always #2 aclk = ~aclk;
    task results;
        if (checked > 0 && error_cnt == 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task lvl(input logic v, input int n);
        other_dom <= v;
        cyc(n);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            ad |= s_axi_awready;
            wd |= s_axi_wready;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        v = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    // Cut a hang short.
    initial begin
        #200000;
        error_cnt++;
        results;
    end
    // Main sequence.
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int gap [3] = '{100, 2500, 600};
        cyc(8);
        aresetn <= 1'b1;
        cyc(1);
        rd(`CXC_OFS_CTRL, d, r);
        chk(d, 32'h1);
        rd(8'h0c, d, r);
        chk({d[29:0], r}, 32'h2);
        wr(8'h0c, 32'h1, r);
        chk(32'(r), 32'h2);
        can_tx_input <= 1'b0;
        cyc(1010);
        chk(32'(bus_tx_dominant), 32'h0);
        rd(`CXC_OFS_STAT, d, r);
        chk(d, 32'h1);
        can_tx_input <= 1'b1;
        cyc(2);
        wr(`CXC_OFS_STAT, 32'h1, r);
        rd(`CXC_OFS_STAT, d, r);
        chk(d, 32'h0);
        for (int k = 0; k < 2; k++) begin
            bus_open <= (k == 0);
            rx_stuck <= (k == 1);
            repeat (4) begin
                can_tx_input <= 1'b0;
                cyc(300);
                can_tx_input <= 1'b1;
                cyc(20);
            end
            rd(`CXC_OFS_STAT, d, r);
            chk(d & 32'ha, (k == 1) ? 32'h8 : 32'ha);
            bus_open <= 1'b0;
            rx_stuck <= 1'b0;
            wr(`CXC_OFS_STAT, 32'h1f, r);
        end
        lvl(1'b1, 2050);
        rd(`CXC_OFS_STATE, d, r);
        chk(d & 32'h1, 32'h1);
        rd(`CXC_OFS_STAT, d, r);
        chk(d, 32'h4);
        lvl(1'b0, 2);
        wr(`CXC_OFS_STAT, 32'h4, r);
        vs_overvoltage <= 1'b1;
        vs_undervoltage <= 1'b1;
        can_tx_input <= 1'b0;
        cyc(3);
        chk(32'({bus_tx_dominant, can_rx_output}), 32'h2);
        can_tx_input <= 1'b1;
        vs_overvoltage <= 1'b0;
        vs_undervoltage <= 1'b0;
        wr(`CXC_OFS_CTRL, 32'h7, r);
        can_tx_input <= 1'b0;
        cyc(3);
        chk(32'({bus_tx_dominant, can_rx_output, term_en}), 32'h1);
        can_tx_input <= 1'b1;
        wr(`CXC_OFS_CTRL, 32'h0, r);
        cyc(2);
        chk(32'({bus_lines_gnd, term_en, split_en}), 32'h4);
        wr(`CXC_OFS_CTRL, 32'h1, r);
        cyc(2);
        chk(32'({bus_lines_gnd, term_en, split_en}), 32'h3);
        wr(`CXC_OFS_CTRL, 32'h69, r);
        cyc(5);
        lvl(1'b1, 100);
        chk(32'(can_rx_output), 32'h1);
        lvl(1'b0, 600);
        rd(`CXC_OFS_STAT, d, r);
        chk(d, 32'h0);
        lvl(1'b1, 510);
        chk(32'({reset_output_low_oe, can_rx_output}), 32'h2);
        lvl(1'b0, 260);
        chk(32'(reset_output_low_oe), 32'h0);
        wr(`CXC_OFS_STAT, 32'h10, r);
        wr(`CXC_OFS_CTRL, 32'h39, r);
        cyc(5);
        foreach (gap[i]) begin
            lvl(1'b1, 600);
            lvl(1'b0, gap[i]);
            lvl(1'b1, 600);
            lvl(1'b0, 2);
            chk(32'(lin_rx_output), (i == 2) ? 32'h0 : 32'h1);
            cyc(2200);
        end
        rd(`CXC_OFS_STAT, d, r);
        chk(d, 32'h10);
        results;
    end
endmodule
`default_nettype wire
